// >>> hw/crv_irq_vector.sv
/*
 * Conversion-result flag, enable and interrupt vector logic with the
 * result memory behind it, reached over APB.
 * Assumes converter inputs synchronous to pclk and an APB master that
 * holds each request until pready.
 */
// Summary of operation
// - writing slot n's result sets flag n
// - reading slot n clears its flag
// - software writes flag register; reset zero
// - sixteen flag bits, bit n is slot n
// - vector codes by priority, overflow first
// - vector read-only, only bits 5..1 used
// - per-flag enable gates interrupt, reset zero
`timescale 1ns/1ps

module crv_irq_vector
#(
	parameter int RES_W = crv_pkg::CRV_RES_W,
	parameter int SLOTS = crv_pkg::CRV_SLOTS
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [crv_pkg::CRV_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter result port
	input wire logic res_valid,
	input wire logic [crv_pkg::CRV_SLOT_W-1:0] res_slot,
	input wire logic [RES_W-1:0] res_data,
	input wire logic conv_time_ovf,
	// interrupt request
	output logic irq
);
	import crv_pkg::*;

	// =====================================================================
	// state
	logic [SLOTS-1:0] flag_reg;
	logic [SLOTS-1:0] flag_next;
	logic [SLOTS-1:0] enable_reg;
	logic [CRV_ST_W-1:0] status_reg;
	logic [CRV_ST_W-1:0] status_next;
	logic [CRV_ST_W-1:0] mask_reg;
	logic [15:0] vector_reg;
	logic [15:0] vector_next;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic irq_reg;
	logic irq_next;
	logic [RES_W-1:0] mem_rd_data;

	// =====================================================================
	// bus decode
	logic access;
	logic done;
	logic wr_done;
	logic rd_done;
	logic hit_slot;
	logic hit_reg;
	logic [CRV_SLOT_W-1:0] bus_slot;
	logic [SLOTS-1:0] set_vec;
	logic [SLOTS-1:0] read_clr;
	logic res_ovf_evt;
	logic sel_flag;
	logic sel_enable;
	logic sel_status;
	logic sel_mask;

	// register decode ignores the byte lanes of the address
	function automatic logic [CRV_ADDR_W-1:0] word_of(input logic [CRV_ADDR_W-1:0] a);
		word_of = {a[CRV_ADDR_W-1:2], 2'h0};
	endfunction

	// the slot window is word aligned; byte address bits 1..0 are ignored
	function automatic logic in_slots(input logic [CRV_ADDR_W-1:0] a);
		in_slots = (a >= CRV_OFS_SLOT_BASE) && (a <= CRV_OFS_SLOT_LAST + 12'h003);
	endfunction

	function automatic logic is_reg(input logic [CRV_ADDR_W-1:0] a);
		logic [CRV_ADDR_W-1:0] w;
		w = word_of(a);
		is_reg = (w == CRV_OFS_FLAG) || (w == CRV_OFS_ENABLE) || (w == CRV_OFS_VECTOR)
			|| (w == CRV_OFS_STATUS) || (w == CRV_OFS_MASK);
	endfunction

	function automatic logic [SLOTS-1:0] onehot(input logic [CRV_SLOT_W-1:0] n);
		onehot = '0;
		onehot[n] = 1'b1;
	endfunction

	// priority encoder: overflow, then time overflow, then lowest slot
	function automatic logic [15:0] encode_vector(
		input logic [CRV_ST_W-1:0] st,
		input logic [SLOTS-1:0] pend
	);
		logic [15:0] v;
		v = CRV_VEC_NONE;
		if (st[CRV_ST_RES_OVF])
		begin
			v = CRV_VEC_RES_OVF;
		end
		else if (st[CRV_ST_TIME_OVF])
		begin
			v = CRV_VEC_TIME_OVF;
		end
		else
		begin
			for (int i = SLOTS - 1; i >= 0; i--)
			begin
				if (pend[i])
				begin
					v = CRV_VEC_SLOT0 + 16'(2 * i);
				end
			end
		end
		encode_vector = v & CRV_VEC_MASK;
	endfunction

	assign access = psel && penable;
	assign done = access && pready_reg;
	assign hit_slot = in_slots(paddr);
	assign hit_reg = is_reg(paddr);
	assign bus_slot = CRV_SLOT_W'((paddr - CRV_OFS_SLOT_BASE) >> 2);
	assign wr_done = done && pwrite && !pslverr_reg;
	assign rd_done = done && !pwrite && !pslverr_reg;
	assign sel_flag = (word_of(paddr) == CRV_OFS_FLAG);
	assign sel_enable = (word_of(paddr) == CRV_OFS_ENABLE);
	assign sel_status = (word_of(paddr) == CRV_OFS_STATUS);
	assign sel_mask = (word_of(paddr) == CRV_OFS_MASK);

	// =====================================================================
	// result memory
	crv_result_mem #(
		.WIDTH(RES_W),
		.DEPTH(SLOTS),
		.AW(CRV_SLOT_W)
	) crv_result_mem_i (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(res_valid),
		.wr_addr(res_slot),
		.wr_data(res_data),
		.rd_en(psel && !penable),
		.rd_addr(bus_slot),
		.rd_data_reg(mem_rd_data)
	);

	// =====================================================================
	// apb handshake
	// one wait state: the first access cycle samples decode and memory
	// data into flops, pready rises for the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else if (access && !pready_reg)
		begin
			pready_reg <= 1'b1;
			// slots are read-only from the bus
			pslverr_reg <= !(hit_reg || (hit_slot && !pwrite));
		end
		else
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= '0;
		end
		else if (access && !pready_reg && !pwrite)
		begin
			if (hit_slot)
			begin
				prdata_reg <= 32'(mem_rd_data);
			end
			else
			begin
				case (word_of(paddr))
					CRV_OFS_FLAG: prdata_reg <= 32'(flag_reg);
					CRV_OFS_ENABLE: prdata_reg <= 32'(enable_reg);
					CRV_OFS_VECTOR: prdata_reg <= 32'(vector_reg);
					CRV_OFS_STATUS: prdata_reg <= 32'(status_reg);
					CRV_OFS_MASK: prdata_reg <= 32'(mask_reg);
					default: prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// =====================================================================
	// result flags
	assign set_vec = res_valid ? onehot(res_slot) : '0;
	assign read_clr = (rd_done && hit_slot) ? onehot(bus_slot) : '0;

	// a new result always wins over a clear in the same cycle
	always_comb
	begin
		flag_next = flag_reg & ~read_clr;
		if (wr_done && sel_flag)
		begin
			// only the written byte lanes change
			for (int b = 0; b < SLOTS / 8; b++)
			begin
				if (pstrb[b])
				begin
					flag_next[b*8 +: 8] = pwdata[b*8 +: 8];
				end
			end
		end
		flag_next = flag_next | set_vec;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_reg <= CRV_FLAG_RST[SLOTS-1:0];
		end
		else
		begin
			flag_reg <= flag_next;
		end
	end

	// =====================================================================
	// flag enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_reg <= CRV_ENABLE_RST[SLOTS-1:0];
		end
		else if (wr_done && sel_enable)
		begin
			for (int b = 0; b < SLOTS / 8; b++)
			begin
				if (pstrb[b])
				begin
					enable_reg[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
		end
	end

	// =====================================================================
	// overflow status, write one to clear
	// a result landing on a slot still flagged overwrote unread data
	assign res_ovf_evt = res_valid && flag_reg[res_slot] && !read_clr[res_slot];

	always_comb
	begin
		status_next = status_reg;
		if (wr_done && pstrb[0] && sel_status)
		begin
			status_next = status_next & ~pwdata[CRV_ST_W-1:0];
		end
		if (res_ovf_evt)
		begin
			status_next[CRV_ST_RES_OVF] = 1'b1;
		end
		if (conv_time_ovf)
		begin
			status_next[CRV_ST_TIME_OVF] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_reg <= CRV_STATUS_RST;
		end
		else
		begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_reg <= CRV_MASK_RST;
		end
		else if (wr_done && pstrb[0] && sel_mask)
		begin
			mask_reg <= pwdata[CRV_ST_W-1:0];
		end
	end

	// =====================================================================
	// vector and interrupt
	// both follow the registered state one cycle later, so a read of the
	// vector right after a flag change may still show the old source
	assign vector_next = encode_vector(status_reg & mask_reg, flag_reg & enable_reg);
	assign irq_next = |(status_reg & mask_reg) || |(flag_reg & enable_reg);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vector_reg <= CRV_VECTOR_RST;
		end
		else
		begin
			vector_reg <= vector_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= irq_next;
		end
	end

	// =====================================================================
	// outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

endmodule

// >>> hw/crv_pkg.sv
/*
 * Constants for the conversion-result flag and interrupt vector block:
 * register offsets, field positions, reset values and vector codes.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
package crv_pkg;

	// =====================================================================
	// sizes
	localparam int CRV_SLOTS = 16;
	localparam int CRV_SLOT_W = 4;
	localparam int CRV_RES_W = 16;
	localparam int CRV_ADDR_W = 12;
	localparam int CRV_REG_W = 16;

	// =====================================================================
	// register byte offsets
	localparam logic [11:0] CRV_OFS_FLAG = 12'h000;
	localparam logic [11:0] CRV_OFS_ENABLE = 12'h004;
	localparam logic [11:0] CRV_OFS_VECTOR = 12'h008;
	localparam logic [11:0] CRV_OFS_STATUS = 12'h00C;
	localparam logic [11:0] CRV_OFS_MASK = 12'h010;
	// result slots: base plus four bytes per slot
	localparam logic [11:0] CRV_OFS_SLOT_BASE = 12'h040;
	localparam logic [11:0] CRV_OFS_SLOT_LAST = 12'h07C;

	// =====================================================================
	// reset values
	localparam logic [15:0] CRV_FLAG_RST = 16'h0000;
	localparam logic [15:0] CRV_ENABLE_RST = 16'h0000;
	localparam logic [15:0] CRV_VECTOR_RST = 16'h0000;
	localparam logic [1:0] CRV_STATUS_RST = 2'h0;
	localparam logic [1:0] CRV_MASK_RST = 2'h0;

	// =====================================================================
	// status and mask layout
	localparam int CRV_ST_RES_OVF = 0;
	localparam int CRV_ST_TIME_OVF = 1;
	localparam int CRV_ST_W = 2;

	// =====================================================================
	// vector field: bits 5..1 carry the value, others read zero
	localparam int CRV_VEC_LSB = 1;
	localparam int CRV_VEC_MSB = 5;
	localparam logic [15:0] CRV_VEC_MASK = 16'h003E;
	localparam logic [15:0] CRV_VEC_NONE = 16'h0000;
	localparam logic [15:0] CRV_VEC_RES_OVF = 16'h0002;
	localparam logic [15:0] CRV_VEC_TIME_OVF = 16'h0004;
	localparam logic [15:0] CRV_VEC_SLOT0 = 16'h0006;
	localparam logic [15:0] CRV_VEC_SLOT_LAST = 16'h0024;

endpackage

// >>> hw/crv_result_mem.sv
/*
 * Result memory: one word per conversion slot, one write port for the
 * converter and one registered read port for the register bus.
 * Assumes a single clock; the array itself is not reset.
 */
`timescale 1ns/1ps

module crv_result_mem
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_reg
);

	// =====================================================================
	// storage
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge pclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// =====================================================================
	// registered read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_data_reg <= '0;
		end
		else if (rd_en)
		begin
			rd_data_reg <= mem[rd_addr];
		end
	end

endmodule

// >>> verification/crv_irq_vector_asserts.sv
/* Port checker for the flag and vector block.
 * Assumes one clock, APB with one wait state; bound below. */
`timescale 1ns/1ps
module crv_irq_vector_asserts
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [crv_pkg::CRV_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter and interrupt
	input wire logic res_valid,
	input wire logic conv_time_ovf,
	input wire logic irq
);
	import crv_pkg::*;
	logic rd_vec;
	logic wr_done;
	assign rd_vec = pready && !pwrite && paddr == CRV_OFS_VECTOR;
	assign wr_done = pready && pwrite;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ===================
	// bus timing
	ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	slot_ro_a: assert property (wr_done && paddr >= CRV_OFS_SLOT_BASE
		&& paddr <= CRV_OFS_SLOT_LAST |-> pslverr)
		else $error("slot write not refused");
	// ===================
	// registers and interrupt
	vec_bits_a: assert property (rd_vec |-> (prdata & ~32'h0000003E) == 32'h0)
		else $error("vector unused bits set");
	vec_code_a: assert property (rd_vec |-> prdata[5:0] <= 6'h24)
		else $error("vector code out of range");
	flag_width_a: assert property (pready && !pwrite && paddr == CRV_OFS_FLAG
		|-> prdata[31:16] == 16'h0)
		else $error("flag register upper bits set");
	irq_rise_a: assert property ($rose(irq) |-> $past(res_valid, 2)
		|| $past(conv_time_ovf, 2) || $past(wr_done, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(pready, 2))
		else $error("irq fell without access");
	cover property ($rose(irq));
	cover property (pslverr);
	cover property (res_valid && pready && !pwrite);
	cover property (rd_vec && prdata[5:0] == 6'h02);
endmodule

bind crv_irq_vector crv_irq_vector_asserts crv_irq_vector_asserts_i (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .res_valid,
	.conv_time_ovf, .irq);

// >>> verification/crv_cpu_model.sv
/* Processor-side model: APB master issuing register accesses.
 * Assumes the slave answers with pready; the bench bounds waits. */
`timescale 1ns/1ps
module crv_cpu_model
(
	// clock
	input wire logic pclk,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [crv_pkg::CRV_ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import crv_pkg::*;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'hFFF;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// software clears or sets flags through plain writes
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show a changed value, not the last one
		paddr <= ~a;
		pwdata <= ~d;
		pstrb <= ~s;
	endtask
endmodule

// >>> verification/tb_crv_irq_vector.sv
/* Self-checking bench for the flag and vector block.
 * Assumes the cpu model for APB; drives the converter port itself. */
`timescale 1ns/1ps
module tb_crv_irq_vector;
	import crv_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic res_valid, conv_time_ovf, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, res_slot;
	logic [15:0] res_data;
	logic [3:0] lanes;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	crv_irq_vector crv_irq_vector_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .res_valid,
		.res_slot, .res_data, .conv_time_ovf, .irq);
	crv_cpu_model crv_cpu_model_i (.pclk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr);
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ===================
	// helpers
	task automatic close_out();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask
	// reads compare data against d; every access checks pslverr
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic ee, input string nm);
		logic [31:0] q;
		logic e;
		crv_cpu_model_i.xfer(w, a, d, lanes, q, e);
		if (!w)
			chk(nm, d, q);
		chk("pslverr", {31'h0, ee}, {31'h0, e});
	endtask
	task automatic conv(input logic [3:0] s, input logic [15:0] d);
		@(posedge pclk);
		res_valid <= 1'b1;
		res_slot <= s;
		res_data <= d;
		@(posedge pclk);
		res_valid <= 1'b0;
		res_slot <= ~s;
		res_data <= ~d;
		repeat (2) @(posedge pclk);
	endtask
	// ===================
	// scenarios
	task automatic t_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		acc(0, CRV_OFS_FLAG, 32'h0, 0, "flag");
		acc(0, CRV_OFS_ENABLE, 32'h0, 0, "enable");
		acc(0, CRV_OFS_VECTOR, 32'h0, 0, "vector");
		acc(0, CRV_OFS_MASK, 32'h0, 0, "mask");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask
	task automatic t_slots();
		acc(1, CRV_OFS_ENABLE, 32'hFFFF, 0, "");
		for (int n = 0; n < 16; n++)
		begin
			conv(4'(n), 16'h0A50 + 16'(n));
			chk("irq", 32'h1, {31'h0, irq});
			acc(0, CRV_OFS_VECTOR, 32'(6 + 2 * n), 0, "vector");
			acc(0, CRV_OFS_FLAG, 32'h1 << n, 0, "flag");
			acc(0, CRV_OFS_SLOT_BASE + 12'(4 * n), 32'h0A50 + n, 0, "slot");
			acc(0, CRV_OFS_FLAG, 32'h0, 0, "flag");
			chk("irq", 32'h0, {31'h0, irq});
		end
		$display("test slots done");
	endtask
	task automatic t_prio();
		acc(1, CRV_OFS_ENABLE, 32'h0208, 0, "");
		conv(4'h3, 16'h0001);
		conv(4'h9, 16'h0002);
		acc(0, CRV_OFS_VECTOR, 32'h0C, 0, "vector");
		acc(1, CRV_OFS_ENABLE, 32'h0200, 0, "");
		acc(0, CRV_OFS_VECTOR, 32'h18, 0, "vector");
		acc(1, CRV_OFS_ENABLE, 32'h0, 0, "");
		acc(0, CRV_OFS_VECTOR, 32'h0, 0, "vector");
		chk("irq", 32'h0, {31'h0, irq});
		acc(1, CRV_OFS_MASK, 32'h3, 0, "");
		@(posedge pclk);
		conv_time_ovf <= 1'b1;
		@(posedge pclk);
		conv_time_ovf <= 1'b0;
		acc(0, CRV_OFS_VECTOR, 32'h04, 0, "vector");
		conv(4'h9, 16'h0003);
		acc(0, CRV_OFS_VECTOR, 32'h02, 0, "vector");
		chk("irq", 32'h1, {31'h0, irq});
		acc(1, CRV_OFS_STATUS, 32'h3, 0, "");
		acc(0, CRV_OFS_VECTOR, 32'h0, 0, "vector");
		$display("test priority done");
	endtask
	task automatic t_sw();
		acc(0, CRV_OFS_FLAG, 32'h0208, 0, "flag");
		acc(1, CRV_OFS_FLAG, 32'h0008, 0, "");
		acc(0, CRV_OFS_FLAG, 32'h0008, 0, "flag");
		acc(1, CRV_OFS_FLAG, 32'h0, 0, "");
		acc(0, CRV_OFS_FLAG, 32'h0, 0, "flag");
		acc(1, CRV_OFS_VECTOR, 32'h3E, 0, "");
		acc(0, CRV_OFS_VECTOR, 32'h0, 0, "vector");
		acc(0, 12'h020, 32'h0, 1, "unmapped");
		acc(1, CRV_OFS_SLOT_BASE, 32'h1234, 1, "");
		acc(0, CRV_OFS_SLOT_BASE, 32'h0A50, 0, "slot");
		$display("test software done");
	endtask
	// leaves flags, enables and mask non-zero so the second reset proves something
	task automatic t_lanes();
		lanes = 4'h1;
		acc(1, CRV_OFS_ENABLE, 32'hFFFF, 0, "");
		acc(0, CRV_OFS_ENABLE, 32'h00FF, 0, "enable");
		lanes = 4'h2;
		acc(1, CRV_OFS_FLAG, 32'hFFFF, 0, "");
		acc(0, CRV_OFS_FLAG, 32'hFF00, 0, "flag");
		chk("irq", 32'h0, {31'h0, irq});
		acc(1, CRV_OFS_MASK, 32'h0, 0, "");
		acc(0, CRV_OFS_MASK, 32'h3, 0, "mask");
		lanes = 4'hF;
		conv(4'h0, 16'h0C01);
		// new result lands on the edge that completes the read of its slot
		fork
			acc(0, CRV_OFS_SLOT_BASE, 32'h0C01, 0, "slot");
			begin
				repeat (2) @(posedge pclk);
				conv(4'h0, 16'h0C02);
			end
		join
		acc(0, CRV_OFS_FLAG, 32'hFF01, 0, "flag");
		acc(0, CRV_OFS_STATUS, 32'h0, 0, "status");
		acc(0, CRV_OFS_VECTOR, 32'h06, 0, "vector");
		chk("irq", 32'h1, {31'h0, irq});
		acc(0, CRV_OFS_SLOT_BASE, 32'h0C02, 0, "slot");
		$display("test lanes done");
	endtask
	initial
	begin
		presetn = 1'b0;
		res_valid = 1'b0;
		res_slot = 4'h0;
		res_data = 16'h0;
		conv_time_ovf = 1'b0;
		lanes = 4'hF;
		t_reset();
		t_slots();
		t_prio();
		t_sw();
		t_lanes();
		t_reset();
		close_out();
	end
endmodule
